// file: rtl/th_pkg.sv
// Shared constants, state encodings and the state record of the sensor port.
// Assumes a single 40 MHz core clock; the cycle counts below derive from it.
package th_pkg;

	// Core clock rate and the timed behaviours derived from it
	localparam int CLK_HZ = 40_000_000;
	localparam int CONV_TIME_MS = 24;
	localparam int TIMEOUT_TIME_MS = 54;
	localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
	localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_TIME_MS;
	localparam int CNT_W = 22;

	// Register select values
	localparam logic [2:0] SEL_RESULT = 3'h0;
	localparam logic [2:0] SEL_CONFIG = 3'h1;
	localparam logic [2:0] SEL_LOWER = 3'h2;
	localparam logic [2:0] SEL_UPPER = 3'h3;
	localparam logic [2:0] SEL_IDENT = 3'h7;
	localparam logic [7:0] SELECT_RESET = 8'h00;

	// Configuration field positions
	localparam int CFG_SHUTDOWN = 0;
	localparam int CFG_THERMOSTAT = 1;
	localparam int CFG_POLARITY = 2;
	localparam int CFG_FAULT_LO = 3;
	localparam int CFG_SINGLE = 7;

	// Values after reset
	localparam logic [6:0] CONFIG_RESET = 7'h00;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [11:0] LOWER_RESET = 12'h4B0;
	localparam logic [11:0] UPPER_RESET = 12'h500;

	// Serial framing
	localparam logic [4:0] HS_CODE = 5'h01;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;

	// Fault queue depths selected by the two queue bits
	localparam logic [2:0] FAULT_Q0 = 3'h1;
	localparam logic [2:0] FAULT_Q1 = 3'h2;
	localparam logic [2:0] FAULT_Q2 = 3'h4;
	localparam logic [2:0] FAULT_Q3 = 3'h6;

	// Part identification, value is arbitrary
	localparam logic [7:0] PART_ID_DEFAULT = 8'h5C;

	typedef enum logic [2:0] {
		TH_IDLE = 3'b000,
		TH_ADDR = 3'b001,
		TH_ACK = 3'b010,
		TH_WDATA = 3'b011,
		TH_RDATA = 3'b100,
		TH_RACK = 3'b101,
		TH_SKIP = 3'b110
	} th_bus_type;

	typedef struct packed {
		th_bus_type st;
		logic scl_d;
		logic sda_d;
		logic [3:0] cnt;
		logic [7:0] sr;
		logic [15:0] tx;
		logic first;
		logic rw;
		logic nack;
		logic [1:0] wbyte;
		logic [7:0] ptr;
		logic [6:0] cfg;
		logic os_flag;
		logic os_busy;
		logic [11:0] result;
		logic [11:0] lower;
		logic [11:0] upper;
		logic [CNT_W-1:0] conv_cnt;
		logic [CNT_W-1:0] to_cnt;
		logic [2:0] hi_cnt;
		logic [2:0] lo_cnt;
		logic alert;
		logic want_hi;
		logic hs;
		logic sda_oe;
		logic conv_run;
		logic alert_pin;
	} th_state_type;

	localparam th_state_type STATE_RESET = '{
		st: TH_IDLE, scl_d: 1'b1, sda_d: 1'b1, ptr: SELECT_RESET, cfg: CONFIG_RESET,
		result: RESULT_RESET, lower: LOWER_RESET, upper: UPPER_RESET,
		want_hi: 1'b1, conv_run: 1'b1, alert_pin: 1'b1, default: '0
	};

endpackage

// file: rtl/th_sync.sv
// Two-flop synchroniser for inputs arriving from outside the core clock.
// Assumes the clock enable is shared with the logic that reads it.
`timescale 1ns/1ps
module th_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= INIT;
			q <= INIT;
		end else if (ce) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// file: rtl/th_sensor_port.sv
// Digital side of the temperature sensor: two-wire slave, mode control,
// register file, conversion timing and the thermostat alert.
// Assumes open-drain pads outside and a converter sample on adc_value.
//
// Overview of operation
// [R1] Master sends fast-mode code before address
// [R2] Code not acked; switch filters to fast
// [R3] Fast mode lasts until STOP
// [R4] Line low 54 ms resets interface
// [R5] Master keeps clock at least 1 kHz
// [R6] Timeout disabled in shutdown
// [R7] Unlimited bytes, each one acknowledged
// [R8] Address ack held low through ninth clock
// [R9] Master ends reads with not-acknowledge
// [R10] Shutdown stops conversions, else continuous
// [R11] Single bit wakes one conversion
// [R12] Single bit reads 0 while busy
// [R13] Conversion takes 24 ms
// [R14] Mode bit picks comparator or interrupt
// [R15] Comparator: set at upper, clear below lower
// [R16] Interrupt: set on crossing, cleared by read
// [R17] Select byte low bits pick register
// [R18] Select resets to result register
// [R19] Master writes select upper bits zero
// [R20] Map: result, config, lower, upper, identity
// [R21] Result twelve bits, high byte first
// [R22] Result reads zero until first conversion
// [R23] Result two's complement, 0.0625 degree step
// [R24] Select kept until rewritten
// [R25] Config layout, all zero at reset
// [R26] Read word captured at read start
`timescale 1ns/1ps
module th_sensor_port #(
	parameter int unsigned CONV_CYCLES = th_pkg::CONV_CYCLES,
	parameter int unsigned TIMEOUT_CYCLES = th_pkg::TIMEOUT_CYCLES,
	parameter logic [7:0] PART_ID = th_pkg::PART_ID_DEFAULT
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Strap and converter
	input wire logic [6:0] slave_address,
	input wire logic [11:0] adc_value,
	output logic conv_run,
	// Status
	output logic hs_mode,
	output logic alert_pin
);
	th_pkg::th_state_type s;
	th_pkg::th_state_type n;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic timeout;
	logic conv_done;
	logic addr_done;
	logic hs_hit;
	logic addr_hit;
	logic rd_clear;
	logic hi_now;
	logic lo_now;
	logic hi_hit;
	logic lo_hit;
	logic [2:0] depth;
	logic [15:0] rd_word;

	// Pins come from another domain; sample twice before use
	th_sync #(.W(1), .INIT(1'b1)) u_scl (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(scl_in),
		.q(scl_s)
	);
	th_sync #(.W(1), .INIT(1'b1)) u_sda (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(sda_in),
		.q(sda_s)
	);

	// Bus events from synchronised levels
	assign scl_rise = scl_s & ~s.scl_d;
	assign scl_fall = ~scl_s & s.scl_d;
	assign start_seen = scl_s & s.scl_d & s.sda_d & ~sda_s;
	assign stop_seen = scl_s & s.scl_d & ~s.sda_d & sda_s;
	localparam int CNT_W_T = th_pkg::CNT_W;
	assign timeout = s.to_cnt == CNT_W_T'(TIMEOUT_CYCLES - 1); // [R4]
	assign conv_done = s.conv_run && s.conv_cnt == CNT_W_T'(CONV_CYCLES - 1); // [R13]

	// Address byte decode at the end of its eighth clock
	assign addr_done = s.st == th_pkg::TH_ADDR && scl_fall && s.cnt == th_pkg::BITS_PER_BYTE;
	assign hs_hit = addr_done && s.first && s.sr[7:3] == th_pkg::HS_CODE; // [R1]
	assign addr_hit = addr_done && !hs_hit && s.sr[7:1] == slave_address;
	assign rd_clear = addr_hit && s.sr[0] && s.cfg[th_pkg::CFG_THERMOSTAT]
		&& s.ptr[2:0] == th_pkg::SEL_RESULT; // [R16]

	// Limit comparison is signed so negative readings order correctly
	assign hi_now = $signed(adc_value) >= $signed(s.upper); // [R23]
	assign lo_now = $signed(adc_value) < $signed(s.lower);
	assign depth = s.cfg[th_pkg::CFG_FAULT_LO+1] ?
		(s.cfg[th_pkg::CFG_FAULT_LO] ? th_pkg::FAULT_Q3 : th_pkg::FAULT_Q2) :
		(s.cfg[th_pkg::CFG_FAULT_LO] ? th_pkg::FAULT_Q1 : th_pkg::FAULT_Q0);
	// One bit wider so a saturated count cannot wrap below the depth
	assign hi_hit = hi_now && ({1'b0, s.hi_cnt} + 4'h1) >= {1'b0, depth};
	assign lo_hit = lo_now && ({1'b0, s.lo_cnt} + 4'h1) >= {1'b0, depth};

	// Word presented to a read; 8-bit registers repeat in both bytes
	always_comb begin
		unique case (s.ptr[2:0]) // [R20]
			th_pkg::SEL_RESULT: rd_word = {s.result, 4'h0}; // [R21]
			th_pkg::SEL_CONFIG: rd_word = {2{s.os_flag, s.cfg}}; // [R12]
			th_pkg::SEL_LOWER: rd_word = {s.lower, 4'h0};
			th_pkg::SEL_UPPER: rd_word = {s.upper, 4'h0};
			th_pkg::SEL_IDENT: rd_word = {PART_ID, PART_ID};
			default: rd_word = 16'h0000;
		endcase
	end

	// Next-state logic for the whole block
	always_comb begin
		n = s;
		n.scl_d = scl_s;
		n.sda_d = sda_s;

		// Serial engine; start and stop override any byte in flight
		if (start_seen) begin
			n.st = th_pkg::TH_ADDR;
			n.cnt = 4'h0;
			n.first = 1'b1;
			n.wbyte = 2'h0;
			n.sda_oe = 1'b0;
		end else if (stop_seen || timeout) begin
			n.st = th_pkg::TH_IDLE; // [R4]
			n.hs = 1'b0; // [R3]
			n.sda_oe = 1'b0;
		end else begin
			unique case (s.st)
				th_pkg::TH_IDLE, th_pkg::TH_SKIP: begin
				end
				th_pkg::TH_ADDR, th_pkg::TH_WDATA: begin
					if (scl_rise) begin
						n.sr = {s.sr[6:0], sda_s};
						n.cnt = s.cnt + 4'h1;
					end
					if (scl_fall && s.cnt == th_pkg::BITS_PER_BYTE) begin
						n.cnt = 4'h0;
						n.first = 1'b0;
						if (hs_hit) begin
							n.hs = 1'b1; // [R2]
							n.st = th_pkg::TH_SKIP;
						end else if (addr_hit) begin
							n.st = th_pkg::TH_ACK;
							n.sda_oe = 1'b1; // [R8]
							n.rw = s.sr[0];
							n.tx = rd_word; // [R26]
						end else if (s.st == th_pkg::TH_WDATA) begin
							n.st = th_pkg::TH_ACK;
							n.sda_oe = 1'b1; // [R7]
							n.wbyte = (s.wbyte == 2'h2) ? 2'h2 : s.wbyte + 2'h1;
							if (s.wbyte == 2'h0) begin
								n.ptr = s.sr; // [R17] [R24]
							end else begin
								unique case (s.ptr[2:0])
									th_pkg::SEL_CONFIG: begin
										if (s.wbyte == 2'h1) begin
											n.cfg = s.sr[6:0]; // [R25] [R14]
										end
										if (s.wbyte == 2'h1 && s.sr[th_pkg::CFG_SHUTDOWN]
											&& s.sr[th_pkg::CFG_SINGLE] && !s.os_busy) begin
											n.os_busy = 1'b1; // [R11]
											n.os_flag = 1'b0; // [R12]
										end
									end
									th_pkg::SEL_LOWER: begin
										if (s.wbyte == 2'h1) n.lower[11:4] = s.sr;
										else n.lower[3:0] = s.sr[7:4];
									end
									th_pkg::SEL_UPPER: begin
										if (s.wbyte == 2'h1) n.upper[11:4] = s.sr;
										else n.upper[3:0] = s.sr[7:4];
									end
									default: begin
									end
								endcase
							end
						end else begin
							n.st = th_pkg::TH_SKIP;
						end
					end
				end
				th_pkg::TH_ACK: begin
					// Release after the ninth clock, or drive first read bit
					if (scl_fall) begin
						n.cnt = 4'h0;
						n.st = s.rw ? th_pkg::TH_RDATA : th_pkg::TH_WDATA;
						n.sda_oe = s.rw & ~s.tx[15];
					end
				end
				th_pkg::TH_RDATA: begin
					// Word rotates so longer reads repeat it
					if (scl_fall) begin
						n.tx = {s.tx[14:0], s.tx[15]}; // [R21]
						n.cnt = s.cnt + 4'h1;
						if (s.cnt == th_pkg::LAST_BIT) begin
							n.st = th_pkg::TH_RACK;
							n.sda_oe = 1'b0;
						end else begin
							n.sda_oe = ~s.tx[14];
						end
					end
				end
				th_pkg::TH_RACK: begin
					if (scl_rise) n.nack = sda_s;
					if (scl_fall) begin
						n.cnt = 4'h0;
						n.st = s.nack ? th_pkg::TH_SKIP : th_pkg::TH_RDATA; // [R9]
						n.sda_oe = ~s.nack & ~s.tx[15];
					end
				end
				default: begin
					n.st = th_pkg::TH_IDLE;
					n.sda_oe = 1'b0;
				end
			endcase
		end

		// Stuck-line watchdog runs only inside a frame and out of shutdown
		if (s.st != th_pkg::TH_IDLE && !s.cfg[th_pkg::CFG_SHUTDOWN]
			&& (!scl_s || !sda_s) && !start_seen && !timeout) begin
			n.to_cnt = s.to_cnt + 1'b1; // [R4]
		end else begin
			n.to_cnt = '0; // [R6]
		end

		// Clears first so a same-cycle set wins
		if (rd_clear) n.alert = 1'b0; // [R16]
		if (n.cfg[th_pkg::CFG_SHUTDOWN] && !s.cfg[th_pkg::CFG_SHUTDOWN]
			&& s.cfg[th_pkg::CFG_THERMOSTAT]) n.alert = 1'b0;

		// Conversion timing and thermostat evaluation
		if (s.conv_run) n.conv_cnt = s.conv_cnt + 1'b1;
		if (conv_done) begin
			n.conv_cnt = '0;
			n.result = adc_value; // [R22]
			n.hi_cnt = hi_now ? ((s.hi_cnt == 3'h7) ? s.hi_cnt : s.hi_cnt + 3'h1) : 3'h0;
			n.lo_cnt = lo_now ? ((s.lo_cnt == 3'h7) ? s.lo_cnt : s.lo_cnt + 3'h1) : 3'h0;
			if (!s.cfg[th_pkg::CFG_THERMOSTAT]) begin
				if (hi_hit) n.alert = 1'b1; // [R15]
				else if (lo_hit) n.alert = 1'b0;
			end else if (s.want_hi && hi_hit) begin
				n.alert = 1'b1; // [R16]
				n.want_hi = 1'b0;
			end else if (!s.want_hi && lo_hit) begin
				n.alert = 1'b1;
				n.want_hi = 1'b1;
			end
			if (s.os_busy) begin
				n.os_busy = 1'b0; // [R11]
				n.os_flag = 1'b1; // [R12]
			end
		end
		n.conv_run = !n.cfg[th_pkg::CFG_SHUTDOWN] || n.os_busy; // [R10]
		if (!n.conv_run) n.conv_cnt = '0;

		// Pin polarity follows the polarity bit
		n.alert_pin = n.cfg[th_pkg::CFG_POLARITY] ? n.alert : ~n.alert;
	end

	// Single state register, frozen while the enable is low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= th_pkg::STATE_RESET; // [R18] [R25]
		end else if (ce) begin
			s <= n;
		end
	end

	// Outputs straight from state; data pin only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = s.sda_oe;
	assign conv_run = s.conv_run;
	assign hs_mode = s.hs;
	assign alert_pin = s.alert_pin;

	// Checks on the serial engine and mode logic
	default clocking cb @(posedge core_clk iff ce);
	endclocking
	default disable iff (!rst_n);

	chk_hs_no_ack: assert property (hs_hit |=> s.hs && !s.sda_oe) // [R2]
		else $error("fast-mode code acknowledged or not entered");
	chk_hs_stop_exit: assert property (stop_seen |=> !s.hs) // [R3]
		else $error("fast mode kept after stop");
	chk_timeout_release: assert property (timeout |=> s.st == th_pkg::TH_IDLE && !s.sda_oe) // [R4]
		else $error("timeout did not reset interface");
	chk_sd_no_timeout: assert property (s.cfg[th_pkg::CFG_SHUTDOWN] |=> s.to_cnt == '0) // [R6]
		else $error("timeout counting in shutdown");
	chk_ack_low_high: assert property (s.st == th_pkg::TH_ACK && s.scl_d |-> s.sda_oe) // [R8]
		else $error("ack released during high phase");
	chk_single_done: assert property (s.os_busy && conv_done |=> s.os_flag && !s.os_busy) // [R11]
		else $error("single conversion did not finish");
	chk_single_busy: assert property (s.os_busy |-> !s.os_flag) // [R12]
		else $error("single bit reads 1 while busy");
	chk_int_read_clear: assert property (rd_clear && !conv_done |=> !s.alert) // [R16]
		else $error("alert not cleared by result read");
	chk_comp_release: assert property (!s.cfg[th_pkg::CFG_THERMOSTAT] && conv_done && lo_hit
		&& !hi_hit |=> !s.alert) // [R15]
		else $error("comparator alert not released");

	cov_hs_entry: cover property (hs_hit ##[1:400] addr_hit);
	cov_single_shot: cover property (s.os_busy ##1 !s.os_busy);
	cov_result_read: cover property (addr_hit && s.sr[0] ##[1:40] s.st == th_pkg::TH_RDATA);
	cov_timeout: cover property (timeout);
endmodule

// file: test/th_master_model.sv
// Two-wire bus master model: frames, bytes and the ninth-clock bit.
// Assumes the data wire is resolved outside from sda_m and the device enable.
`timescale 1ns/1ps
module th_master_model (
	// Wire levels
	input wire logic sda,
	output logic scl,
	output logic sda_m,
	// Byte and ninth bit seen on the wire
	output logic obs_stb,
	output logic [8:0] obs_val
);
	// Idle bus, both lines released
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		obs_stb = 1'b0;
		obs_val = 9'h000;
	end

	// START or repeated START, leaves the clock low
	task automatic start();
		sda_m = 1'b1;
		#50 scl = 1'b1;
		#50 sda_m = 1'b0;
		#50 scl = 1'b0;
	endtask

	// STOP, then the clock stands high until the next frame
	task automatic stop();
		#50 sda_m = 1'b0;
		#50 scl = 1'b1;
		#50 sda_m = 1'b1;
		#100;
	endtask

	// One byte plus ninth bit at 5 MHz, far above the stuck-bus floor
	// Caller picks byte count and the final not-acknowledge
	// Sample late in the high phase, after the device's answer settles
	task automatic xfer(input logic [8:0] tx);
		logic [8:0] rx;
		for (int i = 8; i >= 0; i--) begin
			#50 sda_m = tx[i];
			#50 scl = 1'b1;
			#90 rx[i] = sda;
			#10 scl = 1'b0;
		end
		obs_val = rx;
		obs_stb = 1'b1;
		#1 obs_stb = 1'b0;
	endtask
endmodule

// file: test/th_sensor_port_tb_top.sv
// Self-checking bench of the sensor port: frames, modes and alert.
// Assumes the master model owns the pins and a pull-up on the data wire.
`timescale 1ns/1ps
module th_sensor_port_tb_top;
	localparam int unsigned CONV = 200;
	localparam int unsigned TOUT = 3000;
	localparam logic [7:0] PID = 8'h3C; // Arbitrary identity value
	// Run needs about 0.4 ms; a hang is cut at 1 ms
	localparam int unsigned LIMIT_NS = 1000000;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [6:0] addr = 7'h40;
	logic [11:0] adc = 12'h000;
	logic [11:0] up, ng, nv;
	logic [7:0] hc;
	logic scl, sda_m, sda_oe, obs_stb, conv_run, hs_mode, alert_pin;
	logic [8:0] obs_val;
	logic [8:0] exp_q[$];
	int bad_count = 0;
	int tests_run = 0;
	wire sda_w;

	// Open-drain wire with pull-up
	assign sda_w = sda_m & ~sda_oe;
	always #12.5 core_clk = ~core_clk;

	th_sensor_port #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TOUT), .PART_ID(PID)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda_w),
		.sda_out(), .sda_oe(sda_oe), .slave_address(addr), .adc_value(adc),
		.conv_run(conv_run), .hs_mode(hs_mode), .alert_pin(alert_pin)
	);
	th_master_model mst_u (
		.sda(sda_w), .scl(scl), .sda_m(sda_m), .obs_stb(obs_stb), .obs_val(obs_val)
	);

	// Compare and count
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic chk1(input logic seen, input logic exp);
		check({8'h00, seen}, {8'h00, exp});
	endtask

	// Any unconsumed notes count as one miss
	task automatic finish_test();
		if (exp_q.size() != 0) begin
			bad_count++;
		end
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Oldest note against each byte seen on the wire
	always @(posedge obs_stb) begin
		if (exp_q.size() == 0) begin
			check(obs_val, ~obs_val);
		end else begin
			check(obs_val, exp_q.pop_front());
		end
	end

	task automatic xf(input logic [8:0] tx, input logic [8:0] ex);
		exp_q.push_back(ex);
		mst_u.xfer(tx);
	endtask

	// Write frame: address, select byte, then n data bytes
	task automatic wr(input logic [2:0] sel, input int n, input logic [15:0] d);
		mst_u.start();
		xf({addr, 2'b01}, {addr, 2'b00});
		xf({5'h00, sel, 1'b1}, {5'h00, sel, 1'b0});
		for (int i = 0; i < n; i++) begin
			xf({d[15 - 8 * i -: 8], 1'b1}, {d[15 - 8 * i -: 8], 1'b0});
		end
		mst_u.stop();
	endtask

	// Read frame of n bytes, not-acknowledge after the last
	task automatic rd(input int n, input logic [15:0] w);
		mst_u.start();
		xf({addr, 2'b11}, {addr, 2'b10});
		for (int i = 0; i < n; i++) begin
			xf({8'hFF, i == n - 1}, {w[15 - 8 * i -: 8], i == n - 1});
		end
		mst_u.stop();
	endtask

	// New sample, then room for two full conversions
	task automatic conv(input logic [11:0] v);
		@(posedge core_clk);
		#2 adc = v;
		repeat (2 * CONV + 20) @(posedge core_clk);
	endtask

	task automatic hs_code();
		mst_u.start();
		xf({hc, 1'b1}, {hc, 1'b1});
		chk1(hs_mode, 1'b1);
	endtask

	initial begin
		#(LIMIT_NS);
		bad_count++;
		finish_test();
	end

	initial begin
		void'($urandom(32'hE3E65F8A));
		addr = {2'b10, 5'($urandom())};
		up = {4'h5, 8'($urandom())};
		ng = {4'h8, 8'($urandom())};
		nv = 12'($urandom());
		hc = {5'h01, 3'($urandom())};
		repeat (3) @(posedge core_clk);
		#2 rst_n = 1'b1;
		repeat (8) @(posedge core_clk);
		chk1(conv_run, 1'b1);
		chk1(alert_pin, 1'b1);
		// Reset contents and register map
		rd(2, 16'h0000);
		wr(th_pkg::SEL_CONFIG, 0, 16'h0000);
		rd(2, 16'h0000);
		rd(1, 16'h0000);
		wr(th_pkg::SEL_LOWER, 0, 16'h0000);
		rd(2, {th_pkg::LOWER_RESET, 4'h0});
		wr(th_pkg::SEL_UPPER, 0, 16'h0000);
		rd(2, {th_pkg::UPPER_RESET, 4'h0});
		wr(th_pkg::SEL_IDENT, 0, 16'h0000);
		rd(2, {PID, PID});
		wr(th_pkg::SEL_UPPER, 2, {up, 4'h0});
		rd(2, {up, 4'h0});
		// Comparator at both boundaries, signed compare
		wr(th_pkg::SEL_RESULT, 0, 16'h0000);
		conv(up);
		chk1(alert_pin, 1'b0);
		conv(th_pkg::LOWER_RESET);
		chk1(alert_pin, 1'b0);
		conv(ng);
		chk1(alert_pin, 1'b1);
		rd(2, {ng, 4'h0});
		// Interrupt mode, cleared by a result read
		wr(th_pkg::SEL_CONFIG, 1, 16'h0200);
		conv(up + 12'h001);
		chk1(alert_pin, 1'b0);
		wr(th_pkg::SEL_RESULT, 0, 16'h0000);
		rd(2, {up + 12'h001, 4'h0});
		chk1(alert_pin, 1'b1);
		// Fast code ends at STOP, then a stall in a read
		hs_code();
		mst_u.stop();
		chk1(hs_mode, 1'b0);
		wr(th_pkg::SEL_CONFIG, 0, 16'h0000);
		hs_code();
		mst_u.start();
		xf({addr, 2'b11}, {addr, 2'b10});
		#200 chk1(sda_oe, 1'b1);
		repeat (TOUT + 100) @(posedge core_clk);
		chk1(sda_oe, 1'b0);
		chk1(hs_mode, 1'b0);
		mst_u.stop();
		// Shutdown: no conversions, no stuck-bus release
		wr(th_pkg::SEL_CONFIG, 1, 16'h0100);
		#500 chk1(conv_run, 1'b0);
		mst_u.start();
		xf({addr, 2'b11}, {addr, 2'b10});
		repeat (TOUT + 100) @(posedge core_clk);
		chk1(sda_oe, 1'b1);
		xf({8'hFF, 1'b1}, {8'h01, 1'b1});
		mst_u.stop();
		// Single conversion out of shutdown
		conv(nv);
		wr(th_pkg::SEL_CONFIG, 1, 16'h8100);
		chk1(conv_run, 1'b1);
		rd(1, 16'h0100);
		repeat (2 * CONV) @(posedge core_clk);
		chk1(conv_run, 1'b0);
		rd(1, 16'h8100);
		wr(th_pkg::SEL_RESULT, 0, 16'h0000);
		rd(2, {nv, 4'h0});
		finish_test();
	end
endmodule
